// ### cwd_pkg.sv
// Constants, field positions and the shared decode function of the decoder.
package cwd_pkg;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int OSC_FSM_BIT = 13;
    localparam int OSC_CSW_BIT = 11;
    localparam int OSC_CLKOUT_BIT = 8;
    localparam int OSC_RST_LSB = 4;
    localparam int OSC_EXT_LSB = 0;
    localparam int SUP_DBG_BIT = 13;
    localparam int SUP_STK_BIT = 12;
    localparam int SUP_PPS_BIT = 11;
    localparam int SUP_ZCD_BIT = 10;
    localparam int SUP_BROWNOUT_LEVEL_SEL_BIT = 9;
    localparam int SUP_BOR_LSB = 6;
    localparam int SUP_ULP_BIT = 5;
    localparam int SUP_POWERUP_TIMER_BIT = 1;
    localparam int SUP_MASTER_CLEAR_N_BIT = 0;
    localparam int WDT_CLK_LSB = 11;
    localparam int WDT_WIN_LSB = 8;
    localparam int WDT_MODE_LSB = 5;
    localparam int WDT_PER_LSB = 0;
    localparam logic [13:0] OSC_UNIMPL = 14'h1688;
    localparam logic [13:0] SUP_UNIMPL = 14'h011c;
    localparam logic [13:0] WDT_UNIMPL = 14'h0080;
    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    localparam logic [2:0] RST_EXT_PLL = 3'h2;
    localparam logic [2:0] RST_HF_PLL = 3'h1;
    localparam logic [2:0] RST_HF_32 = 3'h0;
    localparam logic [2:0] RST_HF_1M = 3'h6;
    localparam logic [2:0] FRQ_4M = 3'h2;
    localparam logic [2:0] FRQ_16M = 3'h5;
    localparam logic [2:0] FRQ_32M = 3'h6;
    localparam logic [3:0] DIV_BY4 = 4'h2;
    localparam logic [3:0] DIV_BY1 = 4'h0;
    localparam logic [2:0] EXT_OFF = 3'h4;
    localparam logic [1:0] MODE_ON = 2'h3;
    localparam logic [1:0] MODE_AWAKE = 2'h2;
    localparam logic [1:0] MODE_SW = 2'h1;
    localparam logic [2:0] WIN_OPEN = 3'h7;
    localparam logic [2:0] WIN_FREE_MIN = 3'h6;
    localparam logic [4:0] PER_DEFAULT = 5'h1f;
    localparam logic [4:0] PER_SW_START = 5'h0b;
    // ------------------------------------------------------------------
    // Register map and control fields
    // ------------------------------------------------------------------
    localparam logic [3:0] REG_OSC = 4'h0;
    localparam logic [3:0] REG_SUP = 4'h1;
    localparam logic [3:0] REG_WDT = 4'h2;
    localparam logic [3:0] REG_CTRL = 4'h3;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam int CTL_ZCD_BIT = 0;
    localparam int CTL_BOR_BIT = 1;
    localparam int CTL_WDT_BIT = 2;
    localparam int CTL_LOCK_BIT = 3;
    localparam int CTL_NEW_OSC_SELECT_LSB = 4;
    localparam int CTL_NEW_CLOCK_DIVIDER_LSB = 7;

    // Shared on/off decode of the brown-out and watchdog mode fields.
    function automatic logic cwd_mode_on(input logic [1:0] mode,
                                         input logic sleep,
                                         input logic sw_en);
        case (mode)
            MODE_ON: cwd_mode_on = 1'b1;
            MODE_AWAKE: cwd_mode_on = ~sleep;
            MODE_SW: cwd_mode_on = sw_en;
            default: cwd_mode_on = 1'b0;
        endcase
    endfunction
endpackage

// ### cwd_cfg_if.sv
// Interface carrying latched words and their decoded fields.
`timescale 1ns/1ps
interface cwd_cfg_if;
    logic [13:0] osc_word;
    logic [13:0] sup_word;
    logic [13:0] wdt_word;
    logic [2:0] cur_osc;
    logic [2:0] freq;
    logic [3:0] div;
    logic pll2x;
    logic pll4x;
    logic clkout_on;
    logic [1:0] bor_mode;
    logic [2:0] win;
    logic keyed;
    logic [4:0] period;
    logic period_sw;
    modport top (output osc_word, sup_word, wdt_word,
                 input cur_osc, freq, div, pll2x, pll4x, clkout_on,
                 input bor_mode, win, keyed, period, period_sw);
    modport osc (input osc_word,
                 output cur_osc, freq, div, pll2x, pll4x, clkout_on);
    modport sup (input sup_word, wdt_word,
                 output bor_mode, win, keyed, period, period_sw);
endinterface

// ### cwd_osc_decode.sv
// Decoder of the oscillator word.
`timescale 1ns/1ps
module cwd_osc_decode
    import cwd_pkg::*;
(
    cwd_cfg_if.osc cfg
);
    logic [2:0] rst;
    logic [2:0] ext;
    assign rst = cfg.osc_word[OSC_RST_LSB +: 3];
    assign ext = cfg.osc_word[OSC_EXT_LSB +: 3];

    // The reset code is used as the current selection unchanged.
    always_comb
    begin
        cfg.cur_osc = rst;
        cfg.freq = FRQ_4M;
        cfg.div = DIV_BY1;
        cfg.pll2x = 1'b0;
        cfg.pll4x = 1'b0;
        case (rst)
            RST_HF_1M:
            begin
                cfg.freq = FRQ_4M;
                cfg.div = DIV_BY4;
            end
            RST_HF_PLL:
            begin
                cfg.freq = FRQ_16M;
                cfg.pll2x = 1'b1;
            end
            RST_HF_32: cfg.freq = FRQ_32M;
            RST_EXT_PLL: cfg.pll4x = 1'b1;
            default: cfg.div = DIV_BY1;
        endcase
    end

    // Modes 111..100 are clock input or off, where clock-out may be used.
    assign cfg.clkout_on = (ext >= EXT_OFF) &&
                           !cfg.osc_word[OSC_CLKOUT_BIT];
endmodule

// ### cwd_sup_decode.sv
// Decoder of the supervisor and watchdog words.
`timescale 1ns/1ps
module cwd_sup_decode
    import cwd_pkg::*;
(
    cwd_cfg_if.sup cfg
);
    logic [2:0] win_code;
    logic [4:0] per_code;
    assign win_code = cfg.wdt_word[WDT_WIN_LSB +: 3];
    assign per_code = cfg.wdt_word[WDT_PER_LSB +: 5];
    assign cfg.bor_mode = cfg.sup_word[SUP_BOR_LSB +: 2];

    // Both free codes start fully open; lower codes need keyed access.
    always_comb
    begin
        cfg.win = win_code;
        cfg.keyed = 1'b1;
        if (win_code >= WIN_FREE_MIN)
        begin
            cfg.win = WIN_OPEN;
            cfg.keyed = 1'b0;
        end
    end

    // The blank default hands the period over to software.
    always_comb
    begin
        cfg.period = per_code;
        cfg.period_sw = 1'b0;
        if (per_code == PER_DEFAULT)
        begin
            cfg.period = PER_SW_START;
            cfg.period_sw = 1'b1;
        end
    end
endmodule

// ### cwd_config_word_decoder.sv
// Top of the configuration word decoder with its register port.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module cwd_config_word_decoder
    import cwd_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [13:0] i_osc_word,
    input wire logic [13:0] i_sup_word,
    input wire logic [13:0] i_wdt_word,
    input wire logic i_low_volt_prog_en,
    input wire logic i_sleep,
    input wire logic i_stack_overflow,
    input wire logic i_stack_underflow,
    input wire logic i_shared_input_pin,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    output logic o_failsafe_monitor_en,
    output logic [2:0] o_current_osc_select,
    output logic [2:0] o_internal_freq_select,
    output logic [3:0] o_clock_divider,
    output logic o_pll_2x,
    output logic o_pll_4x,
    output logic [2:0] o_ext_osc_mode,
    output logic o_second_osc_pin_o,
    output logic o_second_osc_pin_oe,
    output logic [2:0] o_new_osc_select,
    output logic [3:0] o_new_clock_divider,
    output logic o_debug_en,
    output logic o_stack_reset,
    output logic o_pin_select_lock,
    output logic o_zero_cross_on,
    output logic o_brownout_low_level,
    output logic o_brownout_on,
    output logic o_ultra_low_brownout_en,
    output logic o_powerup_timer_en,
    output logic o_master_clear_req,
    output logic o_shared_input_pin,
    output logic [2:0] o_watchdog_clock_sel,
    output logic [2:0] o_watchdog_window_live,
    output logic o_watchdog_keyed,
    output logic o_watchdog_on,
    output logic [4:0] o_watchdog_period_live,
    output logic o_watchdog_period_sw
);
    typedef enum logic [1:0] {LK_OPEN, LK_LOCKED, LK_FROZEN} cwd_lock_t;

    // ------------------------------------------------------------------
    // Latched words and decoders
    // ------------------------------------------------------------------
    cwd_cfg_if cfg ();
    logic [13:0] osc_q;
    logic [13:0] sup_q;
    logic [13:0] wdt_q;
    logic lvp_q;
    logic zcd_sw_q;
    logic bor_sw_q;
    logic wdt_sw_q;
    cwd_lock_t lock_q;
    logic [1:0] div4_q;
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_s3_q;
    logic pin_q;
    logic master_clear_n_sel;
    logic wr_ctrl;
    logic chk_live_q;

    assign cfg.osc_word = osc_q;
    assign cfg.sup_word = sup_q;
    assign cfg.wdt_word = wdt_q;

    cwd_osc_decode u_osc (.cfg(cfg));
    cwd_sup_decode u_sup (.cfg(cfg));

    // Words are sampled only while reset is low, so the settings cannot
    // move under running logic; a glitch on the memory bus is harmless.
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            osc_q <= i_osc_word | OSC_UNIMPL;
            sup_q <= i_sup_word | SUP_UNIMPL;
            wdt_q <= i_wdt_word | WDT_UNIMPL;
            lvp_q <= i_low_volt_prog_en;
        end
    end

    assign wr_ctrl = i_wr && (i_addr == REG_CTRL);
    assign master_clear_n_sel = lvp_q || sup_q[SUP_MASTER_CLEAR_N_BIT];

    // ------------------------------------------------------------------
    // Software enables
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            zcd_sw_q <= 1'b0;
            bor_sw_q <= 1'b1;
            wdt_sw_q <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            zcd_sw_q <= i_wdata[CTL_ZCD_BIT];
            bor_sw_q <= i_wdata[CTL_BOR_BIT];
            wdt_sw_q <= i_wdata[CTL_WDT_BIT];
        end
    end

    // New oscillator request fields start at the reset selection and
    // only move when the word allows clock switching.
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_new_osc_select <= cfg.cur_osc;
            o_new_clock_divider <= cfg.div;
        end
        else if (wr_ctrl && osc_q[OSC_CSW_BIT])
        begin
            o_new_osc_select <= i_wdata[CTL_NEW_OSC_SELECT_LSB +: 3];
            o_new_clock_divider <= i_wdata[CTL_NEW_CLOCK_DIVIDER_LSB +: 4];
        end
    end

    // ------------------------------------------------------------------
    // Pin-select lock
    // ------------------------------------------------------------------
    // In one-shot policy the first lock ends in a frozen state that only
    // a reset leaves; otherwise any control write with the lock bit clear unlocks.
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            lock_q <= LK_OPEN;
        else if (wr_ctrl)
        begin
            case (lock_q)
                LK_OPEN:
                    if (i_wdata[CTL_LOCK_BIT])
                        lock_q <= sup_q[SUP_PPS_BIT] ? LK_FROZEN
                                                     : LK_LOCKED;
                LK_LOCKED:
                    if (!i_wdata[CTL_LOCK_BIT])
                        lock_q <= LK_OPEN;
                LK_FROZEN: lock_q <= LK_FROZEN;
                default: lock_q <= LK_OPEN;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            o_pin_select_lock <= 1'b0;
        else
            o_pin_select_lock <= (lock_q != LK_OPEN);
    end

    // ------------------------------------------------------------------
    // Shared pin synchroniser
    // ------------------------------------------------------------------
    // A level is accepted only when the last two stages agree, which
    // rejects a sample that straddled the pin's transition.
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            pin_s3_q <= 1'b1;
            pin_q <= 1'b1;
        end
        else
        begin
            pin_s1_q <= i_shared_input_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            if (pin_s2_q == pin_s3_q)
                pin_q <= pin_s3_q;
        end
    end

    // Master clear asks for reset on a low pin; otherwise the pin is an
    // ordinary input and the request stays idle.
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_master_clear_req <= 1'b0;
            o_shared_input_pin <= 1'b1;
        end
        else
        begin
            o_master_clear_req <= master_clear_n_sel && !pin_q;
            o_shared_input_pin <= master_clear_n_sel ? 1'b1 : pin_q;
        end
    end

    // ------------------------------------------------------------------
    // Stack fault reset and clock-out
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            o_stack_reset <= 1'b0;
        else
            o_stack_reset <= sup_q[SUP_STK_BIT] &&
                (i_stack_overflow || i_stack_underflow);
    end

    // The divider runs always so that clock-out has a fixed phase.
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            div4_q <= 2'h0;
            o_second_osc_pin_oe <= 1'b0;
        end
        else
        begin
            div4_q <= div4_q + 2'h1;
            o_second_osc_pin_oe <= cfg.clkout_on;
        end
    end

    assign o_second_osc_pin_o = div4_q[1];

    // ------------------------------------------------------------------
    // Decoded settings
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_failsafe_monitor_en <= 1'b0;
            o_current_osc_select <= 3'h0;
            o_internal_freq_select <= 3'h0;
            o_clock_divider <= 4'h0;
            o_pll_2x <= 1'b0;
            o_pll_4x <= 1'b0;
            o_ext_osc_mode <= 3'h0;
            o_debug_en <= 1'b0;
            o_zero_cross_on <= 1'b0;
            o_brownout_low_level <= 1'b0;
            o_brownout_on <= 1'b0;
            o_ultra_low_brownout_en <= 1'b0;
            o_powerup_timer_en <= 1'b0;
        end
        else
        begin
            o_failsafe_monitor_en <= osc_q[OSC_FSM_BIT];
            o_current_osc_select <= cfg.cur_osc;
            o_internal_freq_select <= cfg.freq;
            o_clock_divider <= cfg.div;
            o_pll_2x <= cfg.pll2x;
            o_pll_4x <= cfg.pll4x;
            o_ext_osc_mode <= osc_q[OSC_EXT_LSB +: 3];
            o_debug_en <= !sup_q[SUP_DBG_BIT];
            o_zero_cross_on <= !sup_q[SUP_ZCD_BIT] || zcd_sw_q;
            o_brownout_low_level <= sup_q[SUP_BROWNOUT_LEVEL_SEL_BIT];
            o_brownout_on <= cwd_mode_on(cfg.bor_mode, i_sleep,
                                         bor_sw_q);
            o_ultra_low_brownout_en <= !sup_q[SUP_ULP_BIT];
            o_powerup_timer_en <= !sup_q[SUP_POWERUP_TIMER_BIT];
        end
    end

    // Watchdog settings; the live window and period are only seeds here.
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
        begin
            o_watchdog_clock_sel <= 3'h0;
            o_watchdog_window_live <= 3'h0;
            o_watchdog_keyed <= 1'b0;
            o_watchdog_on <= 1'b0;
            o_watchdog_period_live <= 5'h0;
            o_watchdog_period_sw <= 1'b0;
        end
        else
        begin
            o_watchdog_clock_sel <= wdt_q[WDT_CLK_LSB +: 3];
            o_watchdog_window_live <= cfg.win;
            o_watchdog_keyed <= cfg.keyed;
            o_watchdog_on <= cwd_mode_on(wdt_q[WDT_MODE_LSB +: 2],
                                         i_sleep, wdt_sw_q);
            o_watchdog_period_live <= cfg.period;
            o_watchdog_period_sw <= cfg.period_sw;
        end
    end

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------
    // Reads answer one cycle later; unmapped indexes return zero.
    always_ff @(posedge i_clk)
    begin
        if (!i_rstn)
            o_rdata <= 16'h0;
        else if (i_rd)
        begin
            case (i_addr)
                REG_OSC: o_rdata <= {2'h0, osc_q};
                REG_SUP: o_rdata <= {2'h0, sup_q};
                REG_WDT: o_rdata <= {2'h0, wdt_q};
                REG_CTRL: o_rdata <= {5'h0, o_new_clock_divider,
                                      o_new_osc_select, o_pin_select_lock,
                                      wdt_sw_q, bor_sw_q, zcd_sw_q};
                REG_STAT: o_rdata <= {8'h0, lock_q == LK_FROZEN,
                                      o_master_clear_req, pin_q,
                                      o_second_osc_pin_oe, o_watchdog_on,
                                      o_brownout_on, o_zero_cross_on,
                                      lvp_q};
                default: o_rdata <= 16'h0;
            endcase
        end
        else
            o_rdata <= 16'h0;
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Checks start one edge after reset ends, when reset values are gone.
    always_ff @(posedge i_clk)
        chk_live_q <= i_rstn;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn || !chk_live_q);
    chk_failsafe_follow: assert property (
        ##1 o_failsafe_monitor_en == osc_q[OSC_FSM_BIT])
        else $error("fail-safe enable differs from word");
    chk_switch_block: assert property (
        !osc_q[OSC_CSW_BIT] |=> $stable(o_new_osc_select))
        else $error("new oscillator changed while switching blocked");
    chk_clkout_drive: assert property (
        ##1 o_second_osc_pin_oe == ((osc_q[2:0] >= EXT_OFF)
            && !osc_q[OSC_CLKOUT_BIT]))
        else $error("clock-out enable wrong");
    chk_hf_presets: assert property (
        osc_q[6:4] == RST_HF_1M |=> o_internal_freq_select == FRQ_4M
            && o_clock_divider == DIV_BY4)
        else $error("1 MHz preset wrong");
    chk_pll_select: assert property (
        osc_q[6:4] == RST_HF_PLL |=> o_pll_2x && !o_pll_4x
            && o_internal_freq_select == FRQ_16M)
        else $error("2x PLL preset wrong");
    chk_stack_reset: assert property (
        (i_stack_overflow || i_stack_underflow) |=>
            o_stack_reset == sup_q[SUP_STK_BIT])
        else $error("stack fault reset wrong");
    chk_lock_frozen: assert property (
        lock_q == LK_FROZEN |=> lock_q == LK_FROZEN && o_pin_select_lock)
        else $error("frozen lock was released");
    chk_zero_cross: assert property (
        !sup_q[SUP_ZCD_BIT] |=> o_zero_cross_on)
        else $error("zero-cross not forced on");
    chk_master_clear_n_force: assert property (
        lvp_q && !pin_q |=> o_master_clear_req)
        else $error("master clear not honoured");
    chk_window_open: assert property (
        wdt_q[10:9] == 2'h3 |=> o_watchdog_window_live == WIN_OPEN
            && !o_watchdog_keyed)
        else $error("open window decode wrong");
    chk_words_held: assert property (
        $stable(osc_q) && $stable(sup_q) && $stable(wdt_q))
        else $error("configuration changed after reset");
endmodule

// ### cwd_config_word_decoder_tb.sv
// Self-checking testbench of the configuration word decoder.
`timescale 1ns/1ps
module cwd_config_word_decoder_tb
    import cwd_pkg::*;
;
// ----------------------------------------------------------------
// Signals and device
// ----------------------------------------------------------------
logic i_clk, i_rstn, i_low_volt_prog_en, i_sleep, i_stack_overflow;
logic i_stack_underflow, i_shared_input_pin, i_wr, i_rd;
logic [13:0] i_osc_word, i_sup_word, i_wdt_word;
logic [3:0] i_addr, o_clock_divider, o_new_clock_divider;
logic [15:0] i_wdata, o_rdata;
logic o_failsafe_monitor_en, o_pll_2x, o_pll_4x, o_second_osc_pin_o;
logic o_second_osc_pin_oe, o_debug_en, o_stack_reset, o_pin_select_lock;
logic o_zero_cross_on, o_brownout_low_level, o_brownout_on;
logic o_ultra_low_brownout_en, o_powerup_timer_en, o_master_clear_req;
logic o_shared_input_pin, o_watchdog_keyed, o_watchdog_on;
logic o_watchdog_period_sw;
logic [2:0] o_current_osc_select, o_internal_freq_select, o_ext_osc_mode;
logic [2:0] o_new_osc_select, o_watchdog_clock_sel, o_watchdog_window_live;
logic [4:0] o_watchdog_period_live;
logic [31:0] seed;
logic [13:0] o, s, w;
logic mc, bo, wo;
int miscompares, num_checks;

cwd_config_word_decoder u_dut (.i_clk, .i_rstn, .i_osc_word, .i_sup_word,
    .i_wdt_word, .i_low_volt_prog_en, .i_sleep, .i_stack_overflow,
    .i_stack_underflow, .i_shared_input_pin, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_failsafe_monitor_en, .o_current_osc_select,
    .o_internal_freq_select, .o_clock_divider, .o_pll_2x, .o_pll_4x,
    .o_ext_osc_mode, .o_second_osc_pin_o, .o_second_osc_pin_oe,
    .o_new_osc_select, .o_new_clock_divider, .o_debug_en, .o_stack_reset,
    .o_pin_select_lock, .o_zero_cross_on, .o_brownout_low_level,
    .o_brownout_on, .o_ultra_low_brownout_en, .o_powerup_timer_en,
    .o_master_clear_req, .o_shared_input_pin, .o_watchdog_clock_sel,
    .o_watchdog_window_live, .o_watchdog_keyed, .o_watchdog_on,
    .o_watchdog_period_live, .o_watchdog_period_sw);

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
// Sixteen shifts per draw, so neighbouring words are not plain shifts.
function automatic logic [31:0] lfsr(input logic [31:0] v);
    for (int k = 0; k < 16; k++)
        v = {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
    return v;
endfunction

// Preset divider expected for a reset oscillator code.
function automatic logic [3:0] exp_div(input logic [2:0] c);
    return (c == 3'h6) ? 4'h2 : 4'h0;
endfunction

task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
        miscompares++;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
endtask

task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
endtask

// Read data stand only in the cycle after the strobe, so look there.
task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata, exp);
endtask

task automatic wrap_up;
    if (miscompares == 0 && num_checks > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask

// ----------------------------------------------------------------
// Stimulus
// ----------------------------------------------------------------
initial
begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
end

initial
begin
    {i_rstn, i_low_volt_prog_en, i_sleep, i_stack_overflow, i_wr} = '0;
    {i_stack_underflow, i_rd, i_addr, i_wdata} = '0;
    i_shared_input_pin = 1'b1;
    {i_osc_word, i_sup_word, i_wdt_word} = '1;
    seed = 32'he80dd2eb;
    miscompares = 0;
    num_checks = 0;
    // The first pass uses blank words, the rest random ones.
    for (int n = 0; n < 40; n++)
    begin
        seed = lfsr(seed);
        o = (n == 0) ? 14'h3fff : seed[13:0];
        s = (n == 0) ? 14'h3fff : seed[27:14];
        seed = lfsr(seed);
        w = (n == 0) ? 14'h3fff : seed[13:0];
        @(posedge i_clk);
        {i_osc_word, i_sup_word, i_wdt_word} <= {o, s, w};
        i_low_volt_prog_en <= seed[20];
        i_shared_input_pin <= seed[21];
        i_sleep <= seed[22];
        i_rstn <= 1'b0;
        repeat (12) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        mc = seed[20] | s[0];
        bo = s[7] ? (s[6] | ~seed[22]) : s[6];
        chk(o_failsafe_monitor_en, o[13]);
        chk(o_current_osc_select, o[6:4]);
        chk(o_internal_freq_select, o[6:4] == 3'h0 ? 3'h6 :
            o[6:4] == 3'h1 ? 3'h5 : 3'h2);
        chk(o_clock_divider, exp_div(o[6:4]));
        chk(o_pll_2x, o[6:4] == 3'h1);
        chk(o_pll_4x, o[6:4] == 3'h2);
        chk(o_ext_osc_mode, o[2:0]);
        chk(o_second_osc_pin_oe, {o[2] & ~o[8]});
        chk(o_second_osc_pin_o, 1'b1);
        chk(o_debug_en, {~s[13]});
        chk(o_zero_cross_on, {~s[10]});
        chk(o_brownout_low_level, s[9]);
        chk(o_brownout_on, bo);
        chk(o_ultra_low_brownout_en, {~s[5]});
        chk(o_powerup_timer_en, {~s[1]});
        chk(o_watchdog_clock_sel, w[13:11]);
        chk({o_watchdog_window_live, o_watchdog_keyed}, (w[10:9] == 2'h3) ?
            4'he : {w[10:8], 1'b1});
        chk(o_watchdog_on, {w[6] & (w[5] | ~seed[22])});
        chk({o_watchdog_period_sw, o_watchdog_period_live},
            (w[4:0] == 5'h1f) ? 6'h2b : {1'b0, w[4:0]});
        @(posedge i_clk);
        {i_stack_overflow, i_stack_underflow} <= {seed[23], ~seed[23]};
        @(posedge i_clk);
        {i_stack_overflow, i_stack_underflow} <= 2'b00;
        @(negedge i_clk);
        chk(o_stack_reset, s[12]);
        chk(o_second_osc_pin_o, 1'b0);
        wr(REG_CTRL, 16'h000a);
        wr(REG_CTRL, 16'h0002);
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk(o_pin_select_lock, s[11]);
        // The pin passes the synchroniser only some edges after reset.
        chk({o_master_clear_req, o_shared_input_pin},
            {mc & ~seed[21], mc | seed[21]});
        wr(REG_CTRL, 16'h02b7);
        wr(REG_OSC, 16'h0000);
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        wo = w[6] ? (w[5] | ~seed[22]) : w[5];
        chk(o_new_osc_select, o[11] ? 3'h3 : o[6:4]);
        chk(o_new_clock_divider, o[11] ? 4'h5 : exp_div(o[6:4]));
        chk(o_zero_cross_on, 1'b1);
        chk(o_watchdog_on, wo);
        rd(REG_CTRL, {5'h0, (o[11] ? 4'h5 : exp_div(o[6:4])),
            (o[11] ? 3'h3 : o[6:4]), s[11], 3'h7});
        rd(REG_STAT, {8'h0, s[11], mc & ~seed[21], seed[21], o[2] & ~o[8],
            wo, bo, 1'b1, seed[20]});
        rd(REG_OSC, {2'b0, o | OSC_UNIMPL});
        rd(REG_SUP, {2'b0, s | SUP_UNIMPL});
        rd(REG_WDT, {2'b0, w | WDT_UNIMPL});
        rd(4'hf, 16'h0000);
    end
    wrap_up();
end
endmodule
